// >>> amrb_bridge.sv
`timescale 1ns/1ns
`default_nettype none
module amrb_bridge #(
  parameter logic [amrb_pkg::RQ_IDW-1:0] REQUESTER_TAG_VALUE = 8'h00,
  parameter bit HAS_IRQ = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic rst_ni,
  input wire logic [amrb_pkg::AXIL_AW-1:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [amrb_pkg::AXIL_DW-1:0] s_axi_wdata_i,
  input wire logic [amrb_pkg::AXIL_SW-1:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [amrb_pkg::AXIL_AW-1:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [amrb_pkg::AXIL_DW-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [amrb_pkg::RQ_DW-1:0] m_axis_rqst_tdata_o,
  output logic [amrb_pkg::RQ_UW-1:0] m_axis_rqst_tuser_o,
  output logic [amrb_pkg::RQ_IDW-1:0] m_axis_rqst_tid_o,
  output logic m_axis_rqst_tlast_o,
  output logic m_axis_rqst_tvalid_o,
  input wire logic m_axis_rqst_tready_i,
  input wire logic [amrb_pkg::RESP_DW-1:0] memory_response_stream_tdata_i,
  input wire logic memory_response_stream_tvalid_i,
  output logic memory_response_stream_tready_o,
  output logic irq_o
);
  import amrb_pkg::*;

  amrb_state_type state_r, state_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, req_wr_r, req_wr_nxt;
  logic irq_r, irq_nxt;
  logic [AXIL_DW-1:0] rdata_r, rdata_nxt, addr_r, addr_nxt, info_r, info_nxt;
  logic [AXIL_DW-1:0] wdat_r, wdat_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [RQ_UW-1:0] hdr;
  logic [RQ_DW-1:0] payload;
  logic req_fire;

  amrb_stream_if #(.W(REQ_W)) req_in ();
  amrb_stream_if #(.W(REQ_W)) req_out ();
  amrb_stream_if #(.W(AXIL_DW)) resp_in ();
  amrb_stream_if #(.W(AXIL_DW)) resp_out ();

  // Header layout: address, request information, then the write flag.
  always_comb begin
    hdr = '0;
    hdr[HDR_ADDR_LSB +: AXIL_DW] = addr_r;
    hdr[HDR_INFO_LSB +: AXIL_DW] = info_r;
    hdr[HDR_WRITE_BIT] = req_wr_r;
    payload = '0;
    payload[AXIL_DW-1:0] = wdat_r;
  end

  assign req_in.valid = (state_r == ST_ISSUE);
  assign req_in.data = {REQUESTER_TAG_VALUE, hdr, payload, 1'b1};
  assign req_fire = req_in.valid && req_in.ready;
  assign req_out.ready = m_axis_rqst_tready_i;
  assign m_axis_rqst_tvalid_o = req_out.valid;
  assign {m_axis_rqst_tid_o, m_axis_rqst_tuser_o, m_axis_rqst_tdata_o,
          m_axis_rqst_tlast_o} = req_out.data;

  assign resp_in.valid = memory_response_stream_tvalid_i;
  assign resp_in.data = memory_response_stream_tdata_i[AXIL_DW-1:0];
  assign memory_response_stream_tready_o = resp_in.ready;
  // Responses always drain; those that arrive outside a read wait are dropped.
  assign resp_out.ready = 1'b1;

  amrb_slice #(.W(REQ_W)) u_req_slice (.ref_clk_i(ref_clk_i), .rst_ni(rst_ni),
    .in_s(req_in), .out_s(req_out));
  amrb_slice #(.W(AXIL_DW)) u_resp_slice (.ref_clk_i(ref_clk_i), .rst_ni(rst_ni),
    .in_s(resp_in), .out_s(resp_out));

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = RESP_OKAY;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = RESP_OKAY;
  assign irq_o = irq_r;

  always_comb begin
    state_nxt = state_r;
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    arready_nxt = arready_r;
    bvalid_nxt = bvalid_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    addr_nxt = addr_r;
    info_nxt = info_r;
    wdat_nxt = wdat_r;
    req_wr_nxt = req_wr_r;
    cnt_nxt = cnt_r;
    irq_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (s_axi_awvalid_i && s_axi_wvalid_i) begin
          awready_nxt = 1'b1;
          wready_nxt = 1'b1;
          state_nxt = ST_WTAKE;
        end else if (s_axi_arvalid_i) begin
          arready_nxt = 1'b1;
          state_nxt = ST_RTAKE;
        end
      end
      ST_WTAKE: begin
        awready_nxt = 1'b0;
        wready_nxt = 1'b0;
        bvalid_nxt = 1'b1;
        state_nxt = ST_BRESP;
        if (amrb_word(s_axi_awaddr_i) == OFS_ADDR) begin
          addr_nxt = amrb_merge(addr_r, s_axi_wdata_i, s_axi_wstrb_i);
        end else if (amrb_word(s_axi_awaddr_i) == OFS_INFO) begin
          info_nxt = amrb_merge(info_r, s_axi_wdata_i, s_axi_wstrb_i);
        end else if (amrb_word(s_axi_awaddr_i) == OFS_DATA) begin
          wdat_nxt = amrb_merge(wdat_r, s_axi_wdata_i, s_axi_wstrb_i);
          req_wr_nxt = 1'b1;
          bvalid_nxt = 1'b0;
          state_nxt = ST_ISSUE;
        end
      end
      ST_RTAKE: begin
        arready_nxt = 1'b0;
        rvalid_nxt = 1'b1;
        state_nxt = ST_RRESP;
        if (amrb_word(s_axi_araddr_i) == OFS_ADDR) begin
          rdata_nxt = addr_r;
        end else if (amrb_word(s_axi_araddr_i) == OFS_INFO) begin
          rdata_nxt = info_r;
        end else if (amrb_word(s_axi_araddr_i) == OFS_STATUS) begin
          rdata_nxt = {{(AXIL_DW-CNT_W){1'b0}}, cnt_r};
        end else begin
          req_wr_nxt = 1'b0;
          rvalid_nxt = 1'b0;
          state_nxt = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (req_in.ready) begin
          addr_nxt = addr_r + ADDR_STEP;
          cnt_nxt = cnt_r + CNT_ONE;
          irq_nxt = HAS_IRQ;
          if (req_wr_r) begin
            bvalid_nxt = 1'b1;
            state_nxt = ST_BRESP;
          end else begin
            state_nxt = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (resp_out.valid) begin
          rdata_nxt = resp_out.data;
          rvalid_nxt = 1'b1;
          state_nxt = ST_RRESP;
        end
      end
      ST_BRESP: begin
        if (s_axi_bready_i) begin
          bvalid_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      ST_RRESP: begin
        if (s_axi_rready_i) begin
          rvalid_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_ni) begin
      state_r <= ST_IDLE;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      addr_r <= ADDR_RST;
      info_r <= INFO_RST;
      wdat_r <= '0;
      req_wr_r <= 1'b0;
      cnt_r <= '0;
      irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      addr_r <= addr_nxt;
      info_r <= info_nxt;
      wdat_r <= wdat_nxt;
      req_wr_r <= req_wr_nxt;
      cnt_r <= cnt_nxt;
      irq_r <= irq_nxt;
    end
  end

  rst_idle_a: assert property (@(posedge ref_clk_i) !rst_ni |=> state_r == ST_IDLE)
    else $error("Reset did not return the state machine to idle.");
  tlast_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_ni)
    m_axis_rqst_tvalid_o |-> m_axis_rqst_tlast_o)
    else $error("Request beat without last.");
  tid_tag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_ni)
    m_axis_rqst_tvalid_o |-> m_axis_rqst_tid_o == REQUESTER_TAG_VALUE
      && m_axis_rqst_tuser_o[HDR_WRITE_BIT+1 +: 8] == 8'h00)
    else $error("Request identifier differs from the tag.");
  irq_after_req_a: assert property (@(posedge ref_clk_i) disable iff (!rst_ni)
    req_fire |=> irq_o == HAS_IRQ ##1 !irq_o)
    else $error("Interrupt did not follow a request.");
  irq_cause_a: assert property (@(posedge ref_clk_i) disable iff (!rst_ni)
    irq_o |-> HAS_IRQ && $past(req_fire))
    else $error("Interrupt without a request.");
  addr_step_a: assert property (@(posedge ref_clk_i) disable iff (!rst_ni)
    req_fire |=> addr_r == $past(addr_r) + ADDR_STEP)
    else $error("Address did not advance after a request.");
  addr_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_ni)
    state_r == ST_WTAKE && amrb_word(s_axi_awaddr_i) == OFS_ADDR && s_axi_wstrb_i == 4'hf
      |=> addr_r == $past(s_axi_wdata_i) && s_axi_bvalid_o)
    else $error("Address register write lost.");
  rd_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rst_ni)
    state_r == ST_WAIT && resp_out.valid
      |=> s_axi_rvalid_o && s_axi_rdata_o == $past(resp_out.data) && s_axi_rresp_o == RESP_OKAY)
    else $error("Read data did not follow the response frame.");
  rd_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_ni)
    state_r == ST_WAIT && !resp_out.valid |=> !s_axi_rvalid_o)
    else $error("Read answered before its response.");
  wr_issue_a: assert property (@(posedge ref_clk_i) disable iff (!rst_ni)
    state_r == ST_WTAKE && amrb_word(s_axi_awaddr_i) == OFS_DATA
      |=> req_in.valid && !s_axi_bvalid_o)
    else $error("Data write did not start a request.");
  req_to_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_ni)
    req_fire && m_axis_rqst_tready_i && !m_axis_rqst_tvalid_o |=> m_axis_rqst_tvalid_o)
    else $error("Request did not reach the stream output.");
endmodule : amrb_bridge
`default_nettype wire

// >>> amrb_pkg.sv
// Notes on behaviour
// - A 32-bit AXI4-Lite slave port takes memory requests and register accesses.
// - Request address and request information live in registers reached only over AXI4-Lite.
// - The address advances by itself after every request, so sequential accesses need no rewrite.
// - A build-time requester tag from 0 to 255 marks every request stream.
// - With the interrupt option on, an interrupt follows every request sent.
// - Request and response streams each pass a full-handshake pipeline register slice.
// - A state machine sequences request frames from accepted AXI4-Lite requests.
// - Stream master on the request output, stream slave on the response input.
// - Active-low synchronous reset returns the state machine to idle.
// - Every request frame is one beat, so last is set on every valid beat.
// - Request stream carries an 8-bit identifier equal to the tag and 256-bit user header.
// - The interrupt is an active-high edge-type pulse, only with the option enabled.
`default_nettype none
package amrb_pkg;
  localparam int AXIL_AW = 4;
  localparam int AXIL_DW = 32;
  localparam int AXIL_SW = 4;
  localparam int RQ_DW = 512;
  localparam int RQ_UW = 256;
  localparam int RQ_IDW = 8;
  localparam int RESP_DW = 512;
  localparam int REQ_W = RQ_IDW + RQ_UW + RQ_DW + 1;
  localparam int CNT_W = 16;
  localparam int HDR_ADDR_LSB = 0;
  localparam int HDR_INFO_LSB = 32;
  localparam int HDR_WRITE_BIT = 64;
  localparam logic [AXIL_AW-1:0] OFS_ADDR = 4'h0;
  localparam logic [AXIL_AW-1:0] OFS_INFO = 4'h4;
  localparam logic [AXIL_AW-1:0] OFS_DATA = 4'h8;
  localparam logic [AXIL_AW-1:0] OFS_STATUS = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [AXIL_DW-1:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [AXIL_DW-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [AXIL_DW-1:0] INFO_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WTAKE, ST_RTAKE, ST_ISSUE, ST_WAIT, ST_BRESP, ST_RRESP
  } amrb_state_type;

  // Word-aligns a register address; the two low bits never select anything.
  function automatic logic [AXIL_AW-1:0] amrb_word(input logic [AXIL_AW-1:0] a);
    amrb_word = {a[AXIL_AW-1:2], 2'h0};
  endfunction : amrb_word

  // Replaces only the byte lanes whose strobe is set.
  function automatic logic [AXIL_DW-1:0] amrb_merge(input logic [AXIL_DW-1:0] old_v,
                                                     input logic [AXIL_DW-1:0] new_v,
                                                     input logic [AXIL_SW-1:0] strb);
    amrb_merge = old_v;
    for (int i = 0; i < AXIL_SW; i++) begin
      if (strb[i]) begin
        amrb_merge[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
  endfunction : amrb_merge
endpackage : amrb_pkg
`default_nettype wire

// >>> amrb_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface amrb_stream_if #(parameter int W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : amrb_stream_if
`default_nettype wire

// >>> amrb_slice.sv
`timescale 1ns/1ns
`default_nettype none
// Fully registered slice: a main stage plus a skid stage, so ready is a flop too.
module amrb_slice #(parameter int W = 32) (
  input wire logic ref_clk_i,
  input wire logic rst_ni,
  amrb_stream_if.snk in_s,
  amrb_stream_if.src out_s
);
  logic main_v_r, main_v_nxt, skid_v_r, skid_v_nxt, rdy_r, rdy_nxt;
  logic [W-1:0] main_d_r, main_d_nxt, skid_d_r, skid_d_nxt;
  logic in_fire;

  assign in_fire = in_s.valid && rdy_r;
  assign in_s.ready = rdy_r;
  assign out_s.valid = main_v_r;
  assign out_s.data = main_d_r;

  always_comb begin
    main_v_nxt = main_v_r;
    main_d_nxt = main_d_r;
    skid_v_nxt = skid_v_r;
    skid_d_nxt = skid_d_r;
    if (!main_v_r || out_s.ready) begin
      if (skid_v_r) begin
        main_v_nxt = 1'b1;
        main_d_nxt = skid_d_r;
        skid_v_nxt = 1'b0;
      end else begin
        main_v_nxt = in_fire;
        if (in_fire) begin
          main_d_nxt = in_s.data;
        end
      end
    end else if (in_fire) begin
      skid_v_nxt = 1'b1;
      skid_d_nxt = in_s.data;
    end
    rdy_nxt = !skid_v_nxt;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_ni) begin
      main_v_r <= 1'b0;
      skid_v_r <= 1'b0;
      rdy_r <= 1'b1;
      main_d_r <= '0;
      skid_d_r <= '0;
    end else begin
      main_v_r <= main_v_nxt;
      skid_v_r <= skid_v_nxt;
      rdy_r <= rdy_nxt;
      main_d_r <= main_d_nxt;
      skid_d_r <= skid_d_nxt;
    end
  end

  slice_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_ni)
    out_s.valid && !out_s.ready |=> out_s.valid && $stable(out_s.data))
    else $error("Slice output changed while stalled.");
endmodule : amrb_slice
`default_nettype wire

// >>> amrb_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// Memory side stand-in: takes request beats and answers reads. With slow_i set,
// tready is high only every other cycle and replies come late, so the request slice stalls; the response slice never does.
module amrb_mem_model (
  input wire logic ref_clk_i,
  input wire logic rst_ni,
  input wire logic slow_i,
  input wire logic rq_tvalid_i,
  input wire logic rq_tlast_i,
  input wire logic [7:0] rq_tid_i,
  input wire logic [255:0] rq_tuser_i,
  input wire logic [511:0] rq_tdata_i,
  output logic rq_tready_o,
  output logic resp_tvalid_o,
  output logic [511:0] resp_tdata_o,
  input wire logic resp_tready_i,
  output logic [255:0] last_user_o,
  output logic [511:0] last_data_o,
  output logic [8:0] last_tag_o,
  output logic [15:0] n_req_o
);
  logic tick_r;
  logic pend_r;
  logic [2:0] dly_r;
  logic [31:0] raddr_r;
  assign rq_tready_o = !slow_i || tick_r;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_ni) begin
      tick_r <= 1'b0;
      pend_r <= 1'b0;
      dly_r <= 3'h0;
      resp_tvalid_o <= 1'b0;
      resp_tdata_o <= '1;
      n_req_o <= 16'h0;
    end else begin
      tick_r <= ~tick_r;
      if (rq_tvalid_i && rq_tready_o) begin
        n_req_o <= n_req_o + 16'h1;
        last_user_o <= rq_tuser_i;
        last_data_o <= rq_tdata_i;
        last_tag_o <= {rq_tlast_i, rq_tid_i};
        if (!rq_tuser_i[64]) begin
          pend_r <= 1'b1;
          dly_r <= slow_i ? 3'h4 : 3'h0;
          raddr_r <= rq_tuser_i[31:0];
        end
      end
      if (pend_r && dly_r != 3'h0) begin
        dly_r <= dly_r - 3'h1;
      end else if (pend_r && !resp_tvalid_o) begin
        pend_r <= 1'b0;
        resp_tvalid_o <= 1'b1;
        resp_tdata_o <= {480'h0, raddr_r ^ 32'h5a5a_0000};
      end
      // A released data bus must not keep showing the old word.
      if (resp_tvalid_o && resp_tready_i) begin
        resp_tvalid_o <= 1'b0;
        resp_tdata_o <= ~resp_tdata_o;
      end
    end
  end
endmodule : amrb_mem_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import amrb_pkg::*;
  localparam logic [7:0] TAG = 8'hff;
  logic ref_clk_i, rst_ni, slow, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, irq, irq_q;
  logic [1:0] bresp, rresp;
  logic [511:0] tdata, resp_tdata, last_data;
  logic [255:0] tuser, last_user;
  logic [7:0] tid;
  logic tlast, tvalid, tready, resp_tvalid, resp_tready;
  logic [8:0] last_tag;
  logic [15:0] n_req;
  int error_cnt, n_compared, irq_cnt;

  amrb_bridge #(.REQUESTER_TAG_VALUE(TAG), .HAS_IRQ(1'b1)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_ni(rst_ni),
    .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .m_axis_rqst_tdata_o(tdata), .m_axis_rqst_tuser_o(tuser),
    .m_axis_rqst_tid_o(tid), .m_axis_rqst_tlast_o(tlast), .m_axis_rqst_tvalid_o(tvalid),
    .m_axis_rqst_tready_i(tready), .memory_response_stream_tdata_i(resp_tdata),
    .memory_response_stream_tvalid_i(resp_tvalid),
    .memory_response_stream_tready_o(resp_tready), .irq_o(irq)
  );

  amrb_mem_model i_mem (
    .ref_clk_i(ref_clk_i), .rst_ni(rst_ni), .slow_i(slow), .rq_tvalid_i(tvalid),
    .rq_tlast_i(tlast), .rq_tid_i(tid), .rq_tuser_i(tuser), .rq_tdata_i(tdata),
    .rq_tready_o(tready), .resp_tvalid_o(resp_tvalid), .resp_tdata_o(resp_tdata),
    .resp_tready_i(resp_tready), .last_user_o(last_user), .last_data_o(last_data),
    .last_tag_o(last_tag), .n_req_o(n_req)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    if (tvalid === 1'b1 && {tlast, tid} !== {1'b1, TAG}) begin
      error_cnt++;
      $display("mismatch at %0t: got %0h exp %0h", $time, {tlast, tid}, {1'b1, TAG});
    end
    if (irq === 1'b1 && irq_q === 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: got %0h exp %0h", $time, 2'h3, 2'h1);
    end
    if (irq === 1'b1) irq_cnt++;
    irq_q <= irq;
  end

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [511:0] got, input logic [511:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
    int i;
    @(negedge ref_clk_i);
    awaddr = a;
    wdata = v;
    wstrb = s;
    awvalid = 1'b1;
    wvalid = 1'b1;
    bready = 1'b1;
    for (i = 0; i < 100 && awready !== 1'b1; i++) @(negedge ref_clk_i);
    chk(wready, 1'b1);
    @(negedge ref_clk_i);
    awvalid = 1'b0;
    wvalid = 1'b0;
    for (i = 0; i < 100 && bvalid !== 1'b1; i++) @(negedge ref_clk_i);
    chk({bvalid, bresp}, {1'b1, RESP_OKAY});
    @(negedge ref_clk_i);
    bready = 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    int i;
    @(negedge ref_clk_i);
    araddr = a;
    arvalid = 1'b1;
    rready = 1'b1;
    for (i = 0; i < 100 && arready !== 1'b1; i++) @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    arvalid = 1'b0;
    for (i = 0; i < 100 && rvalid !== 1'b1; i++) @(negedge ref_clk_i);
    chk({rvalid, rresp}, {1'b1, RESP_OKAY});
    v = rdata;
    @(negedge ref_clk_i);
    rready = 1'b0;
  endtask : rd

  // One memory request through the data register, judged at the far side.
  task automatic req(input logic w, input logic [31:0] a, input logic [31:0] v);
    logic [15:0] n0;
    int q0;
    n0 = n_req;
    q0 = irq_cnt;
    if (w) wr(OFS_DATA, v, 4'hf);
    else rd(OFS_DATA, d);
    if (!w) chk(d, a ^ 32'h5a5a_0000);
    repeat (3) @(negedge ref_clk_i);
    chk(n_req, n0 + 16'h1);
    chk(last_user, {191'h0, w, 32'h12ff_56ff, a});
    if (w) chk(last_data, {480'h0, v});
    chk(last_tag, {1'b1, TAG});
    chk(irq_cnt, q0 + 1);
    rd(OFS_ADDR, d);
    chk(d, a + 32'h4);
  endtask : req

  task automatic t_idle();
    @(negedge ref_clk_i);
    chk({awready, wready, bvalid, arready, rvalid, tvalid, irq, resp_tready}, 8'h01);
  endtask : t_idle

  task automatic t_regs();
    wr(OFS_ADDR, 32'h0000_1000, 4'hf);
    rd(OFS_ADDR, d);
    chk(d, 32'h0000_1000);
    wr(OFS_INFO, 32'h1234_5678, 4'hf);
    wr(OFS_INFO, 32'hffff_ffff, 4'h5);
    rd(OFS_INFO, d);
    chk(d, 32'h12ff_56ff);
    wr(OFS_STATUS, 32'hffff_ffff, 4'hf);
    rd(OFS_STATUS, d);
    chk(d, 32'h0);
  endtask : t_regs

  task automatic t_stream();
    slow = 1'b0;
    req(1'b1, 32'h0000_1000, 32'hcafe_0001);
    slow = 1'b1;
    req(1'b0, 32'h0000_1004, 32'h0);
    for (int k = 0; k < 4; k++) req(k[0], 32'h0000_1008 + 32'(4 * k), 32'h0bad_0000 + k);
    rd(OFS_STATUS, d);
    chk(d, 32'h6);
  endtask : t_stream

  task automatic t_mid_reset();
    @(negedge ref_clk_i);
    rst_ni = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rst_ni = 1'b1;
    t_idle();
    rd(OFS_ADDR, d);
    chk(d, ADDR_RST);
    rd(OFS_STATUS, d);
    chk(d, 32'h0);
  endtask : t_mid_reset

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    close_out();
  end

  initial begin
    rst_ni = 1'b0;
    slow = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wstrb = 4'h0;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (16) @(negedge ref_clk_i);
    rst_ni = 1'b1;
    t_idle();
    t_regs();
    t_stream();
    t_mid_reset();
    close_out();
  end
endmodule : testbench
`default_nettype wire
